/* tpl_map.svh */
// Constants for the test program loader: record sizes, storage layout, timing
`ifndef TPL_MAP_SVH
`define TPL_MAP_SVH
`define TPL_CHARS_BASIC 8'd96
`define TPL_CHARS_EXT 8'd144
`define TPL_BITS_BASIC 10'd480
`define TPL_BITS_EXT 10'd720
`define TPL_TRACKS 4'd8
`define TPL_LOCS_BASIC 8'd200
`define TPL_LOCS_EXT 8'd135
`define TPL_CHAR_BITS 3'd5
`define TPL_SETUP_NS 100
`define TPL_MAX_RATE_KHZ 600
`define TPL_CLK_MHZ 10
// Least clock cycles between two characters at the top rate (rounded up)
`define TPL_MIN_CHAR_CYC ((`TPL_CLK_MHZ*1000+`TPL_MAX_RATE_KHZ-1)/`TPL_MAX_RATE_KHZ)
`define TPL_ADDR_CHAR 8'd0
`define TPL_ALT_CHAR 8'd3
`define TPL_FIX_CHAR 8'd88
`endif

/* tpl_pkg.sv */
// Types shared by the test program loader
package tpl_pkg;
    typedef enum logic [1:0] {
        TPL_IDLE = 2'b00,
        TPL_LOAD = 2'b01,
        TPL_DONE = 2'b10
    } tpl_state_t;
endpackage

/* tpl_fifo.sv */
// Character FIFO between the link sampler and the record registers
`timescale 1ns/1ns
module tpl_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp, rp, next_wp, next_rp;
    logic [AW:0] cnt, next_cnt;
    logic push, pop;

    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wp = push ? wp + 1'b1 : wp;
        next_rp = pop ? rp + 1'b1 : rp;
        next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end

    assign in_ready = (cnt != DEPTH[AW:0]);
    assign out_valid = (cnt != '0);
    assign out_data = mem[rp];
endmodule

/* tpl_loader.sv */
// Test program loader and sequencer fed from the external program input
`timescale 1ns/1ns
`include "tpl_map.svh"
// How it works
// [R01] With second auxiliary unit: 144 characters, 720 bits, 135 tests a track.
// [R02] Each record carries next track and sector; that test is fetched next. The code only outputs it on next_track/next_sector.
// [R03] A failed test may steer to an alternate next address.
// [R04] Any track and any of 200 locations may be requested directly.
// [R05] Data moves bit serially into the program and auxiliary registers; the code takes each five-bit character in parallel.
// [R06] Loaded characters can be read, altered and written back out.
// [R07] A complete stored program can be streamed out to a tape punch.
// [R08] Read command stays active until the last character is clocked in.
// [R09] Source holds each character 100 ns before the falling clock edge.
// [R10] Characters arrive at no more than 600 kHz.
// [R11] External input lines are active low.
// [R12] Thirty-two buffered fixture control outputs drive relays.
// [R13] Basic record: 96 four-bit characters in 1248 code.
// [R14] One parity bit a character, 480 bits a record.
// [R15] Storage holds 8 tracks of 200 tests each.
// [R16] A character with bad parity raises an error flag.
module tpl_loader
    import tpl_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic second_aux,
    input wire logic start,
    input wire logic [2:0] start_track,
    input wire logic [7:0] start_sector,
    input wire logic test_failed,
    input wire logic ext_clk_n,
    input wire logic [4:0] external_program_input_n,
    input wire logic [7:0] edit_index,
    input wire logic edit_write,
    input wire logic [3:0] edit_data,
    input wire logic punch_ready,
    output logic read_command_n,
    output logic loaded,
    output logic parity_error,
    output logic rate_error,
    output logic [3:0] edit_q,
    output logic [2:0] next_track,
    output logic [7:0] next_sector,
    output logic addr_error,
    output logic [31:0] fixture_ctrl,
    output logic punch_strobe,
    output logic [4:0] punch_data
);
    logic rs1, rst_n;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rs1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1 <= 1'b1;
            rst_n <= rs1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link sampling: clock and data pass two flops first
    logic [5:0] s1, s2;
    logic clk_d, cap;
    logic [4:0] char_in;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= 6'h3f;
            s2 <= 6'h3f;
            clk_d <= 1'b1;
        end else begin
            s1 <= {ext_clk_n, external_program_input_n};
            s2 <= s1;
            clk_d <= s2[5];
        end
    end
    // Falling edge of the line clock captures; data settled 100 ns earlier
    assign cap = clk_d && !s2[5]; // [R09]
    assign char_in = ~s2[4:0]; // [R11]

    tpl_state_t state, next_state;
    logic f_in_ready, f_valid;
    logic [4:0] f_data;
    tpl_fifo #(.WIDTH(5), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(cap && state == TPL_LOAD),
        .in_ready(f_in_ready),
        .in_data(char_in),
        .out_valid(f_valid),
        .out_ready(1'b1),
        .out_data(f_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Record store: four data bits of each character, parity checked
    function automatic logic odd_ok(input logic [4:0] c);
        return ^c;
    endfunction

    logic [3:0] rec [144];
    logic [7:0] cidx, next_cidx, pidx, next_pidx;
    logic [7:0] nchars;
    logic [11:0] gap, next_gap;
    logic next_par, next_rate, next_aerr;
    logic [2:0] next_trk;
    logic [7:0] next_sec;
    logic [7:0] nlocs;
    logic punching, next_punching;

    assign nchars = second_aux ? `TPL_CHARS_EXT : `TPL_CHARS_BASIC; // [R01] [R13]
    assign nlocs = second_aux ? `TPL_LOCS_EXT : `TPL_LOCS_BASIC; // [R01] [R15]

    always_comb begin
        next_state = state;
        next_cidx = cidx;
        next_par = parity_error;
        next_rate = rate_error;
        next_aerr = addr_error;
        next_trk = next_track;
        next_sec = next_sector;
        next_gap = (gap != 12'hfff) ? gap + 12'h001 : gap;
        next_punching = punching;
        next_pidx = pidx;
        case (state)
            TPL_IDLE, TPL_DONE: begin
                // Flag follows the request so a bad address shows before start
                next_aerr = (start_sector >= nlocs); // [R15]
                // A start at a missing location is refused, nothing is read
                if (start && !next_aerr) begin
                    next_state = TPL_LOAD;
                    next_cidx = 8'h00;
                    next_par = 1'b0;
                    next_rate = 1'b0;
                    // Random access to any track and location
                    next_trk = start_track; // [R04]
                    next_sec = start_sector; // [R04]
                end
            end
            TPL_LOAD: begin
                if (cap) begin
                    next_gap = 12'h000;
                    if (gap < 12'(`TPL_MIN_CHAR_CYC)) next_rate = 1'b1; // [R10]
                end
                if (f_valid) begin
                    if (!odd_ok(f_data)) next_par = 1'b1; // [R16] [R14]
                    next_cidx = cidx + 8'h01;
                    if (cidx == nchars - 8'h01) begin
                        next_state = TPL_DONE; // [R08]
                    end
                end
            end
            default: next_state = TPL_IDLE;
        endcase
        // Chained next address with result-dependent alternate
        if (state == TPL_LOAD && next_state == TPL_DONE) begin
            if (test_failed) begin // [R03]
                next_trk = rec[`TPL_ALT_CHAR][2:0];
                next_sec = {rec[`TPL_ALT_CHAR+1], rec[`TPL_ALT_CHAR+2]};
            end else begin // [R02]
                next_trk = rec[`TPL_ADDR_CHAR][2:0];
                next_sec = {rec[`TPL_ADDR_CHAR+1], rec[`TPL_ADDR_CHAR+2]};
            end
        end
        if (state == TPL_DONE && !punching && punch_ready) begin // [R07]
            next_punching = 1'b1;
            next_pidx = 8'h00;
        end else if (punching) begin
            next_pidx = pidx + 8'h01;
            if (pidx == nchars - 8'h01) next_punching = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= TPL_IDLE;
            cidx <= 8'h00;
            gap <= 12'hfff;
            parity_error <= 1'b0;
            rate_error <= 1'b0;
            addr_error <= 1'b0;
            next_track <= 3'h0;
            next_sector <= 8'h00;
            punching <= 1'b0;
            pidx <= 8'h00;
        end else begin
            state <= next_state;
            cidx <= next_cidx;
            gap <= next_gap;
            parity_error <= next_par;
            rate_error <= next_rate;
            addr_error <= next_aerr;
            next_track <= next_trk;
            next_sector <= next_sec;
            punching <= next_punching;
            pidx <= next_pidx;
        end
    end

    // Characters shift into the store one at a time; edits overwrite except in a cycle that writes a loaded character
    always_ff @(posedge clk) begin
        if (state == TPL_LOAD && f_valid) begin
            rec[cidx] <= f_data[3:0]; // [R05]
        end else if (edit_write && edit_index < nchars) begin
            rec[edit_index] <= edit_data; // [R06]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    logic [31:0] next_fix;
    always_comb begin
        next_fix = fixture_ctrl;
        if (state == TPL_DONE) begin
            for (int i = 0; i < 8; i++) begin
                next_fix[i*4 +: 4] = rec[`TPL_FIX_CHAR + 8'(i)]; // [R12]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            read_command_n <= 1'b1;
            loaded <= 1'b0;
            edit_q <= 4'h0;
            fixture_ctrl <= 32'h0000_0000;
            punch_strobe <= 1'b0;
            punch_data <= 5'h00;
        end else begin
            read_command_n <= !(next_state == TPL_LOAD); // [R08] [R11]
            loaded <= (next_state == TPL_DONE);
            edit_q <= (edit_index < nchars) ? rec[edit_index] : 4'h0; // [R06]
            fixture_ctrl <= next_fix;
            punch_strobe <= punching;
            // Parity regenerated so punched characters read back clean
            punch_data <= {~^rec[pidx], rec[pidx]}; // [R07] [R14]
        end
    end

    logic unused;
    assign unused = f_in_ready;
endmodule

/* tpl_source.sv */
// Model of the external program source on the character link
`timescale 1ns/1ns
module tpl_source (
    output logic ext_clk_n,
    output logic [4:0] prog_n
);
    initial begin
        ext_clk_n = 1'b1;
        prog_n = 5'h1f;
    end
    // One character per clock pulse; gap stretches the idle time after it
    task automatic send(input logic [3:0] d, input logic bad, input int gap);
        prog_n = ~{~^d ^ bad, d};
        #400 ext_clk_n = 1'b0;
        #400 ext_clk_n = 1'b1;
        // Pull-ups take released lines back to false
        prog_n = 5'h1f;
        #gap;
    endtask
endmodule

/* tpl_loader_sva.sv */
// Port assertions for the test program loader
`timescale 1ns/1ns
module tpl_loader_sva (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic read_command_n,
    input wire logic loaded,
    input wire logic parity_error,
    input wire logic addr_error,
    input wire logic [31:0] fixture_ctrl,
    input wire logic punch_strobe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence burst_s;
        punch_strobe [*8];
    endsequence
    start_read_a: assert property (
        start && read_command_n |=> !read_command_n || addr_error)
        else $error("no read command");
    addr_refuse_a: assert property (addr_error |-> read_command_n)
        else $error("read at bad address");
    load_excl_a: assert property (!read_command_n |-> !loaded)
        else $error("loaded while reading");
    load_end_a: assert property (
        $rose(read_command_n) |-> ##[0:8] loaded) else $error("not loaded");
    loaded_hold_a: assert property (loaded && !start |=> loaded)
        else $error("record dropped");
    fixture_hold_a: assert property (
        !loaded ##1 !loaded |-> $stable(fixture_ctrl))
        else $error("fixture moved");
    punch_run_a: assert property ($rose(punch_strobe) |-> burst_s)
        else $error("punch burst short");
    punch_done_a: assert property (punch_strobe |-> loaded)
        else $error("punch outside done");
    parity_hold_a: assert property (
        parity_error && !start |=> parity_error) else $error("parity lost");
endmodule
bind tpl_loader tpl_loader_sva tpl_loader_sva_inst (.clk, .arst_n, .start,
    .read_command_n, .loaded, .parity_error, .addr_error, .fixture_ctrl,
    .punch_strobe);

/* test_test_program_loader_sequencer.sv */
// Self-checking bench for the test program loader
`timescale 1ns/1ns
module test_test_program_loader_sequencer;
    logic clk, arst_n, second_aux, start, test_failed, ext_clk_n;
    logic edit_write, punch_ready, read_command_n, loaded, parity_error;
    logic rate_error, addr_error, punch_strobe;
    logic [2:0] start_track, next_track;
    logic [7:0] start_sector, edit_index, next_sector;
    logic [3:0] edit_data, edit_q;
    logic [4:0] prog_n, punch_data;
    logic [31:0] fixture_ctrl;
    int n_errors = 0;
    int n_compared = 0;
    int n_cycles = 0;
    tpl_loader tpl_loader_inst (.clk, .arst_n, .second_aux, .start,
        .start_track, .start_sector, .test_failed, .ext_clk_n,
        .external_program_input_n(prog_n), .edit_index, .edit_write,
        .edit_data, .punch_ready, .read_command_n, .loaded, .parity_error,
        .rate_error, .edit_q, .next_track, .next_sector, .addr_error,
        .fixture_ctrl, .punch_strobe, .punch_data);
    tpl_source tpl_source_inst (.ext_clk_n, .prog_n);
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Address chars lead; fixture chars share one nibble so order is moot
    function automatic logic [3:0] rec(input int i);
        logic [3:0] head [6] = '{4'h5, 4'h0, 4'h7, 4'h2, 4'h0, 4'hc};
        if (i < 6) return head[i];
        return (i >= 88 && i < 96) ? 4'h5 : i[3:0];
    endfunction
    task automatic do_load(input logic sa, fl, input int bad, gap);
        int n;
        n = sa ? 144 : 96;
        {second_aux, test_failed, start} = {sa, fl, 1'b1};
        start_track = 3'h6;
        tick(1);
        start = 1'b0;
        chk("rdcmd", 0, read_command_n);
        chk("start track", 6, next_track);
        chk("start sector", 0, next_sector);
        for (int i = 0; i < n; i++) begin
            if (i == n - 1) chk("rdcmd", 0, read_command_n);
            tpl_source_inst.send(rec(i), i == bad, gap);
        end
        tick(12);
        chk("loaded", 1, loaded);
        chk("rdcmd", 1, read_command_n);
        chk("parity", bad >= 0, parity_error);
        chk("rate", gap < 900, rate_error);
        chk("track", fl ? 2 : 5, next_track);
        chk("sector", fl ? 12 : 7, next_sector);
        chk("fixture", 32'h55555555, fixture_ctrl);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_addr;
        logic [8:0] c [4] = '{9'h0c7, 9'h0c8, 9'h186, 9'h187};
        for (int i = 0; i < 4; i++) begin
            {second_aux, start_sector} = c[i];
            tick(2);
            chk("addr_error", i % 2, addr_error);
            // Only out-of-range requests get a start, which must be refused
            start = (i % 2 == 1);
            tick(1);
            start = 1'b0;
            chk("rdcmd", 1, read_command_n);
        end
        start_sector = 8'h00;
    endtask
    task automatic t_edit;
        edit_index = 8'd9;
        tick(2);
        chk("edit_q", 9, edit_q);
        {edit_data, edit_write} = 5'h15;
        tick(1);
        edit_write = 1'b0;
        tick(2);
        chk("edit_q", 4'ha, edit_q);
    endtask
    task automatic t_punch;
        int cnt = 0;
        punch_ready = 1'b1;
        for (int i = 0; i < 400; i++) begin
            tick(1);
            if (punch_strobe === 1'b1) begin
                if (cnt == 0) chk("punch", 5'h15, punch_data);
                punch_ready = 1'b0;
                cnt++;
            end
        end
        chk("punch count", 144, cnt);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        forever begin
            @(posedge clk);
            n_cycles++;
            if (n_cycles == 20000) begin
                n_errors++;
                test_done();
            end
        end
    end
    initial begin
        {arst_n, second_aux, start, test_failed, edit_write} = '0;
        {punch_ready, start_track, start_sector} = '0;
        {edit_index, edit_data} = '0;
        tick(12);
        arst_n = 1'b1;
        tick(3);
        chk("rdcmd", 1, read_command_n);
        t_addr();
        do_load(0, 0, -1, 1000);
        t_edit();
        do_load(0, 1, -1, 1000);
        do_load(0, 0, 40, 1000);
        // 900 ns a character: too fast, and no line is set twice at once
        do_load(0, 0, -1, 100);
        do_load(1, 0, -1, 1000);
        t_punch();
        test_done();
    end
endmodule
